// ### design/acp_port.sv
// module: three-wire serial configuration port with wishbone status/control
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module acp_port
#(
    parameter logic [7:0] CHIP_ID = 8'h5a
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic select_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import acp_pkg::*;
    logic sclk_s;
    logic seln_s;
    logic sdio_s;
    logic sclk_d_reg;
    logic sel_d_reg;
    logic seln_eff;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_rise;
    acp_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [15:0] instr_reg;
    logic [15:0] instr_next;
    logic rw_reg;
    logic [1:0] len_reg;
    logic [12:0] addr_reg;
    logic [1:0] bytes_left_reg;
    logic [7:0] instr_cnt_reg;
    logic byte_end;
    logic instr_end;
    logic byte_final;
    logic [7:0] rx_byte_reg;
    logic [7:0] byte_next;
    logic [7:0] tx_byte_reg;
    logic load_tx_reg;
    logic armed_reg;
    logic sdio_out_reg;
    logic oe_reg;
    logic wr_en_reg;
    logic [12:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic [7:0] rd_data;
    logic lsb_first;
    logic [7:0] act_data;
    logic port_en_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic wb_hit;
    // ------------------------------------------------------------------
    // pin sampling and edge detection
    // ------------------------------------------------------------------
    // host-driven pins are inputs only; all three cross into clk first
    acp_sync #(.W(3), .RESET_VAL(SYNC_RESET)) u_sync
    (
        .clk(clk),
        .nrst(nrst),
        .async_in({sdio_in, select_n, sclk}),
        .sync_out({sdio_s, seln_s, sclk_s})
    );
    // a disabled port behaves exactly as if select_n were high
    assign seln_eff = seln_s | ~port_en_reg;
    assign sclk_rise = sclk_s & ~sclk_d_reg & ~seln_eff;
    assign sclk_fall = ~sclk_s & sclk_d_reg & ~seln_eff;
    assign sel_rise = seln_eff & ~sel_d_reg;
    // previous sampled levels for edge finding
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclk_d_reg <= 1'b0;
            sel_d_reg <= 1'b1;
        end
        else
        begin
            sclk_d_reg <= sclk_s;
            sel_d_reg <= seln_eff;
        end
    end
    // bit position inside a byte for the chosen shift order
    function automatic logic [2:0] bit_pos(input logic [3:0] cnt, input logic lsb);
        bit_pos = lsb ? cnt[2:0] : (BYTE_LAST - cnt[2:0]);
    endfunction : bit_pos
    // ------------------------------------------------------------------
    // frame sequencing
    // ------------------------------------------------------------------
    assign instr_next = {instr_reg[14:0], sdio_s};
    assign instr_end = (state_reg == ST_INSTR) && sclk_rise && (bit_cnt_reg == INSTR_LAST);
    assign byte_end = (state_reg == ST_DATA) && sclk_rise && (bit_cnt_reg[2:0] == BYTE_LAST);
    // streaming never runs out; counted lengths end after the last byte
    assign byte_final = (len_reg != LEN_STREAM) && (bytes_left_reg == 2'h0);
    // state and bit counter
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
        end
        else if (sel_rise)
        begin
            // a stall is kept only on a byte boundary with bits already taken
            if (state_reg == ST_DONE || bit_cnt_reg[2:0] != 3'h0
                || (state_reg == ST_INSTR && bit_cnt_reg == 4'h0))
            begin
                state_reg <= ST_IDLE;
                bit_cnt_reg <= 4'h0;
            end
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    bit_cnt_reg <= 4'h0;
                    if (!seln_eff)
                        state_reg <= ST_INSTR;
                end
                ST_INSTR:
                begin
                    if (instr_end)
                    begin
                        state_reg <= ST_DATA; // sixteen bits before data
                        bit_cnt_reg <= 4'h0;
                    end
                    else if (sclk_rise)
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                ST_DATA:
                begin
                    if (byte_end)
                    begin
                        bit_cnt_reg <= 4'h0; // eight-bit words
                        if (byte_final)
                            state_reg <= ST_DONE;
                    end
                    else if (sclk_rise)
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                default:
                begin
                    state_reg <= ST_DONE; // waits for select_n to rise
                end
            endcase
        end
    end
    // instruction fields, address stepping and byte count
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            instr_reg <= 16'h0000;
            rw_reg <= 1'b0;
            len_reg <= 2'h0;
            addr_reg <= 13'h0000;
            bytes_left_reg <= 2'h0;
            instr_cnt_reg <= 8'h00;
        end
        else if (state_reg == ST_INSTR && sclk_rise)
        begin
            instr_reg <= instr_next;
            if (bit_cnt_reg == INSTR_LAST)
            begin
                rw_reg <= instr_next[INSTR_RW];
                len_reg <= instr_next[INSTR_LEN_HI:INSTR_LEN_LO];
                bytes_left_reg <= instr_next[INSTR_LEN_HI:INSTR_LEN_LO];
                addr_reg <= instr_next[12:0];
                instr_cnt_reg <= instr_cnt_reg + 8'h01;
            end
        end
        else if (byte_end)
        begin
            // msb-first walks down the map, lsb-first walks up
            addr_reg <= lsb_first ? addr_reg + 13'h0001 : addr_reg - 13'h0001;
            if (bytes_left_reg != 2'h0)
                bytes_left_reg <= bytes_left_reg - 2'h1;
        end
    end
    // ------------------------------------------------------------------
    // write path
    // ------------------------------------------------------------------
    always_comb
    begin
        byte_next = rx_byte_reg;
        byte_next[bit_pos(bit_cnt_reg, lsb_first)] = sdio_s;
    end
    // data bits are taken on rising edges only
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rx_byte_reg <= 8'h00;
        else if (state_reg == ST_DATA && sclk_rise)
            rx_byte_reg <= byte_next;
    end
    // one write strobe per completed byte of a write frame
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_en_reg <= 1'b0;
            wr_addr_reg <= 13'h0000;
            wr_data_reg <= 8'h00;
        end
        else
        begin
            wr_en_reg <= byte_end && !rw_reg;
            if (byte_end)
            begin
                wr_addr_reg <= addr_reg;
                wr_data_reg <= byte_next;
            end
        end
    end
    acp_regs #(.CHIP_ID(CHIP_ID), .GRADE(8'h00)) u_regs
    (
        .clk(clk),
        .nrst(nrst),
        .wr_en(wr_en_reg),
        .wr_addr(wr_addr_reg),
        .wr_data(wr_data_reg),
        .rd_addr(addr_reg),
        .rd_data(rd_data),
        .lsb_first(lsb_first),
        .act_idx(wb_adr_i[4:2]),
        .act_data(act_data)
    );
    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // byte is fetched one cycle after the address settles, long before a fall
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            load_tx_reg <= 1'b0;
            tx_byte_reg <= 8'h00;
        end
        else
        begin
            load_tx_reg <= instr_end || byte_end;
            if (load_tx_reg)
                tx_byte_reg <= rd_data;
        end
    end
    // read bits change after falling edges so the host samples on rising
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sdio_out_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
        else if (state_reg == ST_IDLE)
            armed_reg <= 1'b0;
        else if (state_reg == ST_DATA && rw_reg && sclk_fall)
        begin
            sdio_out_reg <= tx_byte_reg[bit_pos(bit_cnt_reg, lsb_first)];
            armed_reg <= 1'b1;
        end
    end
    // driver on only in the data or done state of a read while selected
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            oe_reg <= 1'b0;
        else
            oe_reg <= (state_reg == ST_DATA || state_reg == ST_DONE) && rw_reg
                && armed_reg && !seln_eff;
    end
    assign sdio_out = sdio_out_reg;
    assign sdio_oe = oe_reg;
    // ------------------------------------------------------------------
    // wishbone slave: ack one cycle after the request is seen
    // ------------------------------------------------------------------
    assign wb_hit = wb_cyc_i && wb_stb_i && !ack_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ack_reg <= 1'b0;
            port_en_reg <= CTRL_EN_RESET;
        end
        else
        begin
            ack_reg <= wb_hit;
            if (wb_hit && wb_we_i && wb_adr_i == WB_CTRL && wb_sel_i[0])
                port_en_reg <= wb_dat_i[0];
        end
    end
    // read data; unmapped words answer zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            dat_reg <= 32'h0000_0000;
        else if (wb_hit && !wb_we_i)
        begin
            if (wb_adr_i == WB_STATUS)
                dat_reg <= {16'h0000, instr_cnt_reg, 5'h00, port_en_reg, lsb_first,
                    (state_reg != ST_IDLE)};
            else if (wb_adr_i == WB_CTRL)
                dat_reg <= {31'h0000_0000, port_en_reg};
            else if (wb_adr_i >= WB_ACTIVE_FIRST && wb_adr_i <= WB_ACTIVE_LAST
                && wb_adr_i[1:0] == 2'h0)
                dat_reg <= {24'h00_0000, act_data};
            else
                dat_reg <= 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_DESELECT_FREEZES: assert property (seln_eff && state_reg != ST_IDLE
        && !sel_rise |=> $stable(bit_cnt_reg))
        else $error("bit counter moved while deselected");
    AST_FRAME_OPENS: assert property (state_reg == ST_IDLE && !seln_eff
        |=> state_reg == ST_INSTR)
        else $error("frame did not open on select");
    AST_STREAM_STAYS: assert property (byte_end && len_reg == LEN_STREAM
        |=> state_reg == ST_DATA)
        else $error("streaming frame ended");
    AST_STALL_ABORT: assert property (sel_rise && state_reg == ST_DATA
        && bit_cnt_reg[2:0] != 3'h0 |=> state_reg == ST_IDLE)
        else $error("mid-byte deselect did not abort");
    AST_HIGHZ_DESELECTED: assert property (seln_eff [*2] |-> !sdio_oe)
        else $error("data pin driven while deselected");
    AST_INSTR_SIXTEEN: assert property (instr_end |=> state_reg == ST_DATA
        && bit_cnt_reg == 4'h0)
        else $error("data phase not entered after sixteen bits");
    AST_LENGTH_END: assert property (byte_end && byte_final |=> state_reg == ST_DONE)
        else $error("counted frame did not finish");
    AST_FIELDS_DECODED: assert property (state_reg == ST_DATA
        && $past(state_reg) == ST_INSTR |-> rw_reg == $past(instr_reg[INSTR_RW - 1])
        && len_reg == $past(instr_reg[INSTR_LEN_HI - 1:INSTR_LEN_LO - 1])
        && addr_reg == {$past(instr_reg[ADDR_W - 2:0]), $past(sdio_s)})
        else $error("instruction fields decoded wrongly");
    AST_DRIVE_ONLY_READ: assert property (sdio_oe |-> rw_reg
        && (state_reg == ST_DATA || state_reg == ST_DONE))
        else $error("data pin driven outside a read");
    AST_WRITE_ON_BYTE: assert property (wr_en_reg |-> $past(sclk_rise)
        && $past(bit_cnt_reg[2:0]) == BYTE_LAST && !rw_reg)
        else $error("write strobe not on an eight-bit boundary");
    AST_DRIVE_AFTER_FALL: assert property (!$stable(sdio_out_reg) |-> $past(sclk_fall))
        else $error("read bit changed without a falling edge");
    COV_READ: cover property (sdio_oe && state_reg == ST_DONE);
    COV_WRITE: cover property (wr_en_reg);
    COV_STALL: cover property (sel_rise && state_reg == ST_DATA && bit_cnt_reg == 4'h0);
    COV_STREAM: cover property (byte_end && len_reg == LEN_STREAM);
endmodule : acp_port
`default_nettype wire

// ### include/acp_pkg.sv
// package: constants, register map and state type of the converter config serial port
// How it works
// - while select_n is high every serial clock and data edge is ignored.
// - a frame opens as soon as select_n is low; its bits are taken as serial clock rises.
// - select_n held low forever keeps a streaming frame going; counted frames end and wait in done.
// - select_n may go high at a byte boundary; the frame resumes afterwards.
// - with select_n high the data pin driver is released.
// - every frame begins with sixteen instruction bits shifted in first.
// - the two length bits fix one, two, three bytes or streaming.
// - the first instruction bit chooses read or write for the frame.
// - the data pin is driven only in the data phase and the done state of reads.
// - serial clock and select_n are inputs only, driven by the host.
// - all register data moves in eight-bit words.
// - data bits go msb first after reset, lsb first when configured.
// - shadowed writes apply together when transfer is written; transfer then self-clears.
`default_nettype none
package acp_pkg;
    // ------------------------------------------------------------------
    // serial register space
    // ------------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam logic [12:0] REG_CFG = 13'h0000;
    localparam logic [12:0] REG_ID = 13'h0001;
    localparam logic [12:0] REG_GRADE = 13'h0002;
    localparam logic [12:0] REG_XFER = 13'h00ff;
    localparam logic [12:0] SHADOW_FIRST = 13'h0008;
    localparam logic [12:0] SHADOW_LAST = 13'h000f;
    localparam int SHADOW_N = 8;
    localparam logic [7:0] CFG_RESET = 8'h18;
    localparam logic [7:0] SHADOW_RESET = 8'h00;
    localparam int CFG_LSB_HI = 6;
    localparam int CFG_LSB_LO = 1;
    localparam int CFG_SRST_HI = 5;
    localparam int CFG_SRST_LO = 2;
    localparam int XFER_BIT = 0;
    // ------------------------------------------------------------------
    // instruction layout and counts
    // ------------------------------------------------------------------
    localparam int INSTR_RW = 15;
    localparam int INSTR_LEN_HI = 14;
    localparam int INSTR_LEN_LO = 13;
    localparam logic [3:0] INSTR_LAST = 4'hf;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    // ------------------------------------------------------------------
    // wishbone map
    // ------------------------------------------------------------------
    localparam logic [7:0] WB_STATUS = 8'h00;
    localparam logic [7:0] WB_CTRL = 8'h04;
    localparam logic [7:0] WB_ACTIVE_FIRST = 8'h20;
    localparam logic [7:0] WB_ACTIVE_LAST = 8'h3c;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam logic [2:0] SYNC_RESET = 3'h2;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_INSTR = 2'h1,
        ST_DATA = 2'h3,
        ST_DONE = 2'h2
    } acp_state_t;
endpackage : acp_pkg
`default_nettype wire

// ### design/acp_sync.sv
// module: two-stage synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module acp_sync
#(
    parameter int W = 3,
    parameter logic [2:0] RESET_VAL = 3'h0
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // ------------------------------------------------------------------
    // one pair of flops per pin; first stage feeds only the second
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic meta_reg;
            logic stab_reg;
            // meta_reg may go metastable, so nothing but stab_reg reads it
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    meta_reg <= RESET_VAL[g];
                    stab_reg <= RESET_VAL[g];
                end
                else
                begin
                    meta_reg <= async_in[g];
                    stab_reg <= meta_reg;
                end
            end
            assign sync_out[g] = stab_reg;
        end
    endgenerate
endmodule : acp_sync
`default_nettype wire

// ### design/acp_regs.sv
// module: byte register space with config, id, shadowed bank and transfer bit
`timescale 1ns/1ps
`default_nettype none
module acp_regs
#(
    parameter logic [7:0] CHIP_ID = 8'h5a,
    parameter logic [7:0] GRADE = 8'h00
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [acp_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [acp_pkg::ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data,
    output logic lsb_first,
    input wire logic [2:0] act_idx,
    output logic [7:0] act_data
);
    import acp_pkg::*;
    // chip id value above is arbitrary
    logic [7:0] cfg_reg;
    logic xfer_reg;
    logic [7:0] master_reg [SHADOW_N];
    logic [7:0] active_reg [SHADOW_N];
    logic soft_rst;
    // ------------------------------------------------------------------
    // decode shared by write and read paths
    // ------------------------------------------------------------------
    function automatic logic is_shadow(input logic [12:0] a);
        is_shadow = (a >= SHADOW_FIRST) && (a <= SHADOW_LAST);
    endfunction : is_shadow
    // either mirrored soft reset bit restores defaults; it never sticks
    assign soft_rst = wr_en && (wr_addr == REG_CFG)
        && (wr_data[CFG_SRST_HI] || wr_data[CFG_SRST_LO]);
    // nibbles are mirrored so either copy of the bit selects the order
    assign lsb_first = cfg_reg[CFG_LSB_HI] | cfg_reg[CFG_LSB_LO];
    // config register, not shadowed
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cfg_reg <= CFG_RESET;
        else if (soft_rst)
            cfg_reg <= CFG_RESET;
        else if (wr_en && wr_addr == REG_CFG)
            cfg_reg <= wr_data;
    end
    // transfer bit: a write of one sets it, hardware clears it next cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            xfer_reg <= 1'b0;
        else if (wr_en && wr_addr == REG_XFER && wr_data[XFER_BIT])
            xfer_reg <= 1'b1; // set wins over the self-clear
        else
            xfer_reg <= 1'b0;
    end
    // ------------------------------------------------------------------
    // shadowed bank: master copy written serially, active copy on transfer
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < SHADOW_N; g++)
        begin : g_shadow
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    master_reg[g] <= SHADOW_RESET;
                    active_reg[g] <= SHADOW_RESET;
                end
                else if (soft_rst)
                begin
                    master_reg[g] <= SHADOW_RESET;
                    active_reg[g] <= SHADOW_RESET;
                end
                else
                begin
                    if (wr_en && is_shadow(wr_addr) && wr_addr[2:0] == 3'(g))
                        master_reg[g] <= wr_data;
                    if (xfer_reg)
                        active_reg[g] <= master_reg[g]; // all together
                end
            end
        end
    endgenerate
    // read mux; unknown addresses read zero
    always_comb
    begin
        if (rd_addr == REG_CFG)
            rd_data = cfg_reg;
        else if (rd_addr == REG_ID)
            rd_data = CHIP_ID;
        else if (rd_addr == REG_GRADE)
            rd_data = GRADE;
        else if (rd_addr == REG_XFER)
            rd_data = {7'h00, xfer_reg};
        else if (is_shadow(rd_addr))
            rd_data = master_reg[rd_addr[2:0]];
        else
            rd_data = 8'h00;
    end
    assign act_data = active_reg[act_idx];
    AST_XFER_APPLIES: assert property (@(posedge clk) disable iff (!nrst)
        xfer_reg && !soft_rst |=> active_reg[0] == $past(master_reg[0]) && !xfer_reg)
        else $error("transfer did not apply shadow bank or did not self-clear");
endmodule : acp_regs
`default_nettype wire

// ### bench/acp_host.sv
// host model: serial master of the three-wire port
`timescale 1ns/1ps
`default_nettype none
module acp_host
(
    output logic sclk,
    output logic select_n,
    output logic host_bit,
    output logic host_oe,
    input wire logic sdio
);
    logic lsb = 1'b0;
    logic stall = 1'b0;
    logic [1:0] len = 2'h0;
    int nb = 1;
    logic cut = 1'b0;
    // clock idles low, select high, pin released
    initial
    begin
        sclk = 1'b0;
        select_n = 1'b1;
        host_bit = 1'b0;
        host_oe = 1'b0;
    end
    // bit set while clock low, taken at the rise
    task automatic bit_cycle(input logic b, output logic s);
        host_bit <= b;
        #80 sclk <= 1'b1;
        s = sdio;
        #80 sclk <= 1'b0;
    endtask : bit_cycle
    // frame: 16 instruction bits msb first, then nb data bytes
    task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] wd,
        output logic [7:0] q);
        logic [15:0] ins;
        logic s;
        ins = {rd, len, a};
        select_n <= 1'b0;
        host_oe <= 1'b1;
        #80;
        for (int i = 15; i >= 0; i--)
            bit_cycle(ins[i], s);
        host_oe <= !rd; // let go before the device turns the pin
        // pause at the byte boundary
        if (stall)
        begin
            #80 select_n <= 1'b1;
            #400 select_n <= 1'b0;
            #80;
        end
        for (int k = 0; k < nb; k++)
            for (int i = 0; i < 8; i++)
            begin
                bit_cycle(wd[lsb ? i : 7 - i], s);
                q[lsb ? i : 7 - i] = s;
            end
        // a stray bit leaves the frame mid-byte, so the release aborts it
        if (cut)
            bit_cycle(1'b0, s);
        #80 select_n <= 1'b1;
        host_oe <= 1'b0;
        #400;
    endtask : frame
endmodule : acp_host
`default_nettype wire

// ### bench/acp_port_bench.sv
// self-checking bench of the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module acp_port_bench;
    import acp_pkg::*;
    localparam logic [7:0] ID = 8'h3c; // arbitrary value
    logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic sclk, select_n, host_bit, host_oe, sdio, sdio_out, sdio_oe;
    logic [7:0] adr = 8'h00, b;
    logic [31:0] wdat = 32'h0, rdat, q;
    int miscompares = 0, num_checks = 0;
    logic [12:0] a_tab[4] = '{13'h0008, 13'h000f, 13'h0001, 13'h0040};
    logic [7:0] w_tab[4] = '{8'ha5, 8'h3c, 8'hff, 8'h77};
    logic [7:0] e_tab[4] = '{8'ha5, 8'h3c, ID, 8'h00};
    always #5 clk = ~clk;
    // pin level: device, else host, else pull-up
    assign sdio = sdio_oe ? sdio_out : (host_oe ? host_bit : 1'b1);
    acp_host i_host (.sclk(sclk), .select_n(select_n), .host_bit(host_bit),
        .host_oe(host_oe), .sdio(sdio));
    acp_port #(.CHIP_ID(ID)) i_dut (.clk(clk), .nrst(nrst), .sclk(sclk),
        .select_n(select_n), .sdio_in(sdio), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // classic cycle held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        {cyc, stb} <= 2'h0;
        if (n >= 50)
            miscompares++;
        @(posedge clk);
    endtask : wb
    task automatic stop_test;
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    initial
    begin
        #300000;
        miscompares++;
        stop_test();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        chk("oe", 32'h0, {31'h0, sdio_oe});
        wb(1'b0, WB_STATUS, 32'h0);
        chk("status", 32'h4, q);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 4; i++)
        begin
            i_host.frame(1'b0, a_tab[i], w_tab[i], b);
            i_host.frame(1'b1, a_tab[i], 8'h00, b);
            chk("row", {24'h0, e_tab[i]}, {24'h0, b});
        end
        wb(1'b0, WB_ACTIVE_FIRST, 32'h0);
        chk("held", 32'h0, q);
        i_host.frame(1'b0, REG_XFER, 8'h01, b);
        wb(1'b0, WB_ACTIVE_LAST, 32'h0);
        chk("copied", 32'h3c, q);
        i_host.frame(1'b1, REG_XFER, 8'h00, b);
        chk("xfer", 32'h0, {24'h0, b});
        chk("oe_off", 32'h0, {31'h0, sdio_oe});
        wb(1'b0, WB_STATUS, 32'h0);
        chk("count", 32'h0a04, q);
        wb(1'b1, WB_CTRL, 32'h0);
        i_host.frame(1'b0, 13'h0008, 8'h00, b);
        wb(1'b0, WB_STATUS, 32'h0);
        chk("disabled", 32'h0a00, q);
        wb(1'b1, WB_CTRL, 32'h1);
        i_host.len = 2'h1;
        i_host.nb = 2;
        i_host.frame(1'b0, 13'h000b, 8'h66, b);
        i_host.frame(1'b1, 13'h0009, 8'h00, b);
        chk("two_bytes", 32'ha5, {24'h0, b});
        i_host.frame(1'b1, 13'h000b, 8'h00, b);
        chk("second_byte", 32'h66, {24'h0, b});
        i_host.len = LEN_STREAM;
        i_host.cut = 1'b1;
        i_host.frame(1'b0, 13'h000d, 8'h11, b);
        i_host.len = 2'h0;
        i_host.nb = 1;
        i_host.cut = 1'b0;
        i_host.frame(1'b1, 13'h000c, 8'h00, b);
        chk("stream", 32'h11, {24'h0, b});
        i_host.frame(1'b0, REG_CFG, 8'h5a, b);
        i_host.lsb = 1'b1;
        i_host.stall = 1'b1;
        i_host.frame(1'b0, 13'h0009, 8'h01, b);
        i_host.frame(1'b0, REG_XFER, 8'h01, b);
        wb(1'b0, 8'h24, 32'h0);
        chk("lsb_first", 32'h01, q);
        stop_test();
    end
endmodule : acp_port_bench
`default_nettype wire
